// ==== inc/pmc_pkg.sv ====
// Package for the power mode controller: modes, pin states, timing.
// Assumes a 25 MHz core clock standing in for the oscillator input.
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_RESET = 3'h0,
    PMC_RUN = 3'h1,
    PMC_IDLE = 3'h2,
    PMC_IDLE_RST = 3'h3,
    PMC_PDOWN = 3'h4,
    PMC_WAKE = 3'h5,
    PMC_EMUL = 3'h6
  } pmc_mode_type;

  typedef struct packed {
    logic addr_latch_strobe;
    logic program_fetch_strobe;
    logic strobe_weak;
    logic port0_float;
    logic port2_address;
    logic ports_weak;
  } pmc_pins_type;

  localparam int PMC_CYC_W = 3;
  localparam logic [PMC_CYC_W-1:0] PMC_PHASES_PER_CYCLE = 3'h6;
  localparam logic [PMC_CYC_W-1:0] PMC_LAST_PHASE = 3'h5;
  localparam logic [PMC_CYC_W-1:0] PMC_HALF_PHASE = 3'h3;
  localparam logic [3:0] PMC_RST_TICKS = 4'hc;
  localparam logic [4:0] PMC_PIN_IDLE = 5'h0f;
  localparam logic [1:0] PMC_RST_CYCLES = 2'h2;
  localparam logic [1:0] PMC_IDLE_RST_CYCLES = 2'h2;
  localparam int PMC_SETTLE_MS = 10;
  localparam int PMC_CLK_KHZ = 25000;
  localparam int PMC_SETTLE_CYC = PMC_SETTLE_MS * PMC_CLK_KHZ / 12;
endpackage

// ==== rtl/pmc_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_core_clk.
`timescale 1ns/100ps
module pmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      meta_reg <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// ==== rtl/pmc_top.sv ====
// Power mode controller: idle, power down and emulation mode sequencing.
// Assumes pins are asynchronous; i_resetn is only a simulation reset.
// Behaviour
// - Internal phase clock is the oscillator input divided by two.
// - Idle request stops processor execution; peripherals keep their enable.
// - Idle keeps RAM and register contents by freezing their write enables.
// - Idle ends on any enabled interrupt or hardware reset.
// - Reset during idle lets execution run up to two machine cycles.
// - In that window RAM writes are blocked, port writes are not.
// - Power down request stops the oscillator after the requesting instruction.
// - Power down keeps RAM and register values.
// - Power down ends on hardware reset or external interrupt.
// - Reset exit reinitialises registers but keeps RAM; interrupt keeps both.
// - Interrupt wake needs enabled level irq; low restarts, high completes.
// - After wake interrupt, execution resumes after the power down instruction.
// - Idle: strobes at one, port 0 floats and port 2 addresses if external.
// - Power down: strobes at zero, port 0 floats if external program.
// - Emulation floats port 0, weakly pulls others and strobes, oscillator on.
// - Ordinary reset leaves emulation mode.
// - Outside idle and power down, reset recognised only when high for two machine cycles, oscillator on.
// - Normal operation pulses address strobe at one sixth oscillator rate.
`timescale 1ns/100ps
module pmc_top (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_rst_pin,
  input wire logic i_ext_irq_zero_n,
  input wire logic i_ext_irq_one_n,
  input wire logic i_irq_zero_en,
  input wire logic i_irq_one_en,
  input wire logic i_irq_zero_level,
  input wire logic i_irq_one_level,
  input wire logic i_any_irq,
  input wire logic i_idle_req,
  input wire logic i_pdown_req,
  input wire logic i_ext_program,
  input wire logic i_ale_sense_n,
  input wire logic i_fetch_sense_n,
  output logic o_osc_run,
  output logic o_phase_en,
  output logic o_cpu_run,
  output logic o_periph_run,
  output logic o_ram_wr_en,
  output logic o_port_wr_en,
  output logic o_regs_init,
  output logic o_resume_next,
  output pmc_pkg::pmc_pins_type o_pins,
  output pmc_pkg::pmc_mode_type o_mode
);
  logic [4:0] pin_sync;
  logic rst_s, irq0_s, irq1_s, ale_s, fetch_s;

  pmc_sync #(.W(5), .RST_VAL(pmc_pkg::PMC_PIN_IDLE)) u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_rst_pin, i_ext_irq_zero_n, i_ext_irq_one_n,
              i_ale_sense_n, i_fetch_sense_n}),
    .o_sync(pin_sync)
  );
  assign {rst_s, irq0_s, irq1_s, ale_s, fetch_s} = pin_sync;

  pmc_pkg::pmc_mode_type mode_reg, mode_next;
  logic div2_reg;
  logic [2:0] phase_reg;
  logic [3:0] rst_cnt_reg;
  logic [1:0] win_cnt_reg;
  logic cycle_end, rst_seen, ale_pulse;
  logic wake_zero, wake_one, wake_low, wake_high;
  logic once_strap;

  // Divide by two
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      div2_reg <= 1'b0;
    end else if (o_osc_run) begin
      div2_reg <= ~div2_reg;
    end
  end

  wire phase_tick = o_osc_run & div2_reg;
  assign cycle_end = phase_tick & (phase_reg == pmc_pkg::PMC_LAST_PHASE);

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      phase_reg <= '0;
    end else if (phase_tick) begin
      phase_reg <= cycle_end ? '0 : phase_reg + 3'h1;
    end
  end

  // Reset pin held high for two machine cycles with oscillator running
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || !rst_s) begin
      rst_cnt_reg <= '0;
    end else if (phase_tick && rst_cnt_reg != pmc_pkg::PMC_RST_TICKS) begin
      rst_cnt_reg <= rst_cnt_reg + 4'h1;
    end
  end
  assign rst_seen = rst_cnt_reg == pmc_pkg::PMC_RST_TICKS;

  // Enabled level-sensitive external interrupt wake sources
  assign wake_zero = i_irq_zero_en & i_irq_zero_level;
  assign wake_one = i_irq_one_en & i_irq_one_level;
  assign wake_low = (wake_zero & ~irq0_s) | (wake_one & ~irq1_s);
  assign wake_high = ~((wake_zero & ~irq0_s) | (wake_one & ~irq1_s));

  // Emulation strap: address strobe low, fetch high, at reset release
  assign once_strap = ~ale_s & fetch_s;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pmc_pkg::PMC_RESET: begin
        if (!rst_s) begin
          mode_next = once_strap ? pmc_pkg::PMC_EMUL : pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_RUN: begin
        if (rst_seen) begin
          mode_next = pmc_pkg::PMC_RESET;
        end else if (i_pdown_req) begin
          mode_next = pmc_pkg::PMC_PDOWN;
        end else if (i_idle_req) begin
          mode_next = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (rst_s) begin
          mode_next = pmc_pkg::PMC_IDLE_RST;
        end else if (i_any_irq) begin
          mode_next = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_IDLE_RST: begin
        if (rst_seen || win_cnt_reg == pmc_pkg::PMC_IDLE_RST_CYCLES) begin
          mode_next = pmc_pkg::PMC_RESET;
        end
      end
      pmc_pkg::PMC_PDOWN: begin
        if (rst_s) begin
          mode_next = pmc_pkg::PMC_RESET;
        end else if (wake_low) begin
          mode_next = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        if (rst_seen) begin
          mode_next = pmc_pkg::PMC_RESET;
        end else if (wake_high) begin
          mode_next = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_EMUL: begin
        if (rst_seen) begin
          mode_next = pmc_pkg::PMC_RESET;
        end
      end
      default: mode_next = pmc_pkg::PMC_RESET;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mode_reg <= pmc_pkg::PMC_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Machine cycles run after reset arrives in idle
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || mode_reg != pmc_pkg::PMC_IDLE_RST) begin
      win_cnt_reg <= '0;
    end else if (cycle_end) begin
      win_cnt_reg <= win_cnt_reg + 2'h1;
    end
  end

  // Address strobe pulse, two per machine cycle
  assign ale_pulse = (phase_reg == '0) ||
    (phase_reg == pmc_pkg::PMC_HALF_PHASE);

  wire is_run = mode_next == pmc_pkg::PMC_RUN;
  wire is_idle = mode_next == pmc_pkg::PMC_IDLE;
  wire is_win = mode_next == pmc_pkg::PMC_IDLE_RST;
  wire is_pd = mode_next == pmc_pkg::PMC_PDOWN;
  wire is_emul = mode_next == pmc_pkg::PMC_EMUL;
  wire is_rst = mode_next == pmc_pkg::PMC_RESET;

  pmc_pkg::pmc_pins_type pins_next;
  always_comb begin
    pins_next = '0;
    pins_next.addr_latch_strobe = ale_pulse;
    pins_next.program_fetch_strobe = 1'b1;
    if (is_idle) begin
      pins_next.addr_latch_strobe = 1'b1;
      pins_next.program_fetch_strobe = 1'b1;
      pins_next.port0_float = i_ext_program;
      pins_next.port2_address = i_ext_program;
    end else if (is_pd || mode_next == pmc_pkg::PMC_WAKE) begin
      pins_next.addr_latch_strobe = 1'b0;
      pins_next.program_fetch_strobe = 1'b0;
      pins_next.port0_float = i_ext_program;
    end else if (is_emul) begin
      pins_next.addr_latch_strobe = 1'b1;
      pins_next.program_fetch_strobe = 1'b1;
      pins_next.strobe_weak = 1'b1;
      pins_next.port0_float = 1'b1;
      pins_next.ports_weak = 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_osc_run <= 1'b1;
      o_phase_en <= 1'b0;
      o_cpu_run <= 1'b0;
      o_periph_run <= 1'b0;
      o_ram_wr_en <= 1'b0;
      o_port_wr_en <= 1'b0;
      o_regs_init <= 1'b1;
      o_resume_next <= 1'b0;
      o_pins <= '0;
      o_mode <= pmc_pkg::PMC_RESET;
    end else begin
      o_osc_run <= ~is_pd;
      o_phase_en <= phase_tick;
      o_cpu_run <= is_run | is_win;
      o_periph_run <= ~is_pd & ~is_rst;
      o_ram_wr_en <= is_run;
      o_port_wr_en <= is_run | is_win;
      o_regs_init <= is_rst;
      o_resume_next <= mode_reg == pmc_pkg::PMC_WAKE && is_run;
      o_pins <= pins_next;
      o_mode <= mode_next;
    end
  end

  idle_no_ram_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_IDLE |-> !o_ram_wr_en && !o_cpu_run)
    else $error("RAM writable or cpu running in idle");

  idle_keep_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_IDLE |-> o_periph_run && o_osc_run
    && !o_regs_init)
    else $error("Peripherals stopped or registers reset in idle");

  idle_exit_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    mode_reg == pmc_pkg::PMC_IDLE && !rst_s && i_any_irq
    |=> mode_reg == pmc_pkg::PMC_RUN)
    else $error("Interrupt did not end idle");

  win_ram_block_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_IDLE_RST |-> !o_ram_wr_en && o_port_wr_en)
    else $error("Reset window access wrong");

  pd_osc_stop_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_PDOWN |-> !o_osc_run && !o_pins.addr_latch_strobe)
    else $error("Oscillator or strobe active in power down");

  pd_keep_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_PDOWN |-> !o_ram_wr_en && !o_regs_init
    && !o_cpu_run)
    else $error("State not kept in power down");

  idle_strobe_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_IDLE |-> o_pins.addr_latch_strobe &&
    o_pins.program_fetch_strobe)
    else $error("Strobes not high in idle");

  emul_pins_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_EMUL |-> o_pins.port0_float && o_pins.ports_weak
    && o_osc_run)
    else $error("Emulation pin state wrong");

  emul_exit_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    mode_reg == pmc_pkg::PMC_EMUL && rst_seen
    |=> mode_reg == pmc_pkg::PMC_RESET)
    else $error("Reset did not end emulation");

  pd_prio_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    mode_reg == pmc_pkg::PMC_RUN && !rst_seen && i_pdown_req
    |=> mode_reg == pmc_pkg::PMC_PDOWN)
    else $error("Power down request not taken first");

  sequence s_win_enter;
    mode_reg == pmc_pkg::PMC_IDLE ##1 mode_reg == pmc_pkg::PMC_IDLE_RST;
  endsequence
  win_bound_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    s_win_enter |-> ##[0:30] mode_reg == pmc_pkg::PMC_RESET)
    else $error("Reset window ran past two cycles");

  sequence s_pd_wake;
    mode_reg == pmc_pkg::PMC_PDOWN && !rst_s && wake_low;
  endsequence
  pd_wake_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    s_pd_wake |=> mode_reg == pmc_pkg::PMC_WAKE && o_osc_run)
    else $error("Low wake level did not restart oscillator");

  wake_resume_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    mode_reg == pmc_pkg::PMC_WAKE && !rst_seen && wake_high
    |=> mode_reg == pmc_pkg::PMC_RUN && o_resume_next)
    else $error("Wake did not complete with resume");

  resume_pulse_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_resume_next |=> !o_resume_next)
    else $error("Resume pulse longer than one cycle");

  reset_regs_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    o_mode == pmc_pkg::PMC_RESET |-> o_regs_init && !o_cpu_run)
    else $error("Registers not reinitialised in reset");

  div_half_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    phase_tick |=> !phase_tick)
    else $error("Phase tick not divided by two");

  sequence s_ale_rise;
    $rose(ale_pulse) && o_osc_run;
  endsequence
  sequence s_osc_kept;
    o_osc_run [*5] ##1 1'b1;
  endsequence
  ale_rate_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    s_ale_rise ##1 s_osc_kept |-> $rose(ale_pulse))
    else $error("Address strobe not at one sixth of the clock");

  rst_cycles_a: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn)
    mode_reg == pmc_pkg::PMC_RUN && !rst_s |=> mode_reg != pmc_pkg::PMC_RESET)
    else $error("Reset taken without held pin");
endmodule

// ==== verification/pmc_ext_model.sv ====
// Outside party: reset pin, two interrupt pins and a tester on the strobes.
// Assumes the bench calls its tasks from one process; pins move after edges.
`timescale 1ns/100ps
module pmc_ext_model #(
  parameter int SETTLE = 40
) (
  input wire logic i_core_clk,
  output logic o_rst_pin,
  output logic [1:0] o_irq_n,
  output logic o_ale_sense_n,
  output logic o_fetch_sense_n
);
  initial begin
    o_rst_pin = 1'b0;
    o_irq_n = 2'h3;
    o_ale_sense_n = 1'b1;
    o_fetch_sense_n = 1'b1;
  end
  // Level wake: low restarts, held through settling, high completes
  task automatic wake(input int idx);
    @(posedge i_core_clk) o_irq_n[idx] <= 1'b0;
    repeat (SETTLE) @(posedge i_core_clk);
    o_irq_n[idx] <= 1'b1;
  endtask
  // Reset pulse; with emul the address strobe is held low past release
  task automatic pin_reset(input int cyc, input logic emul);
    @(posedge i_core_clk);
    o_ale_sense_n <= !emul;
    o_rst_pin <= 1'b1;
    repeat (cyc) @(posedge i_core_clk);
    o_rst_pin <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    o_ale_sense_n <= 1'b1;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench: mode changes are checked against a queue of notes.
// Assumes the power mode controller and the outside party model.
`timescale 1ns/100ps
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic any_irq = 1'b0;
  logic idle_req = 1'b0;
  logic pdown_req = 1'b0;
  logic ext = 1'b0;
  logic pend = 1'b0;
  logic [1:0] irq_en = 2'h3;
  logic [1:0] irq_lvl = 2'h3;
  logic [1:0] irq_n;
  logic rst_pin, ale_n, fetch_n;
  logic osc, phase, cpu, periph, ram_wr, port_wr, regs_init, resume;
  logic [5:0] flags;
  pmc_pkg::pmc_pins_type pins;
  pmc_pkg::pmc_mode_type mode, last, e;
  pmc_pkg::pmc_mode_type q[$];
  int num_errors = 0;
  int checks = 0;
  assign flags = {osc, periph, cpu, ram_wr, port_wr, regs_init};
  always #20 i_core_clk = ~i_core_clk;
  pmc_top pmc_top_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_rst_pin(rst_pin), .i_ext_irq_zero_n(irq_n[0]),
    .i_ext_irq_one_n(irq_n[1]), .i_irq_zero_en(irq_en[0]),
    .i_irq_one_en(irq_en[1]), .i_irq_zero_level(irq_lvl[0]),
    .i_irq_one_level(irq_lvl[1]), .i_any_irq(any_irq),
    .i_idle_req(idle_req), .i_pdown_req(pdown_req), .i_ext_program(ext),
    .i_ale_sense_n(ale_n), .i_fetch_sense_n(fetch_n), .o_osc_run(osc),
    .o_phase_en(phase), .o_cpu_run(cpu), .o_periph_run(periph),
    .o_ram_wr_en(ram_wr), .o_port_wr_en(port_wr), .o_regs_init(regs_init),
    .o_resume_next(resume), .o_pins(pins), .o_mode(mode));
  pmc_ext_model pmc_ext_model_inst (.i_core_clk(i_core_clk),
    .o_rst_pin(rst_pin), .o_irq_n(irq_n), .o_ale_sense_n(ale_n),
    .o_fetch_sense_n(fetch_n));
  task automatic report(input logic [7:0] g, x);
    num_errors++;
    $display("wrong value at %0t: %h expected %h", $time, g, x);
  endtask
  task automatic cmp_mode(input pmc_pkg::pmc_mode_type g, x);
    checks++;
    if (g !== x) report(8'(g), 8'(x));
  endtask
  task automatic cmp_pins(input logic [5:0] g, x);
    checks++;
    if (g !== x) report(8'(g), 8'(x));
  endtask
  task automatic cmp_flags(input logic [5:0] g, x, m);
    checks++;
    if ((g & m) !== (x & m)) report(8'(g & m), 8'(x & m));
  endtask
  task automatic results;
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_mode(input pmc_pkg::pmc_mode_type m, input int lim);
    int n = 0;
    while (mode !== m && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
    cmp_mode(mode, m);
  endtask
  task automatic enter(input logic id, input logic pd);
    q.push_back(pd ? pmc_pkg::PMC_PDOWN : pmc_pkg::PMC_IDLE);
    @(posedge i_core_clk);
    idle_req <= id;
    pdown_req <= pd;
    @(posedge i_core_clk);
    idle_req <= 1'b0;
    pdown_req <= 1'b0;
    wait_mode(pd ? pmc_pkg::PMC_PDOWN : pmc_pkg::PMC_IDLE, 10);
  endtask
  task automatic period(input logic b, input logic [5:0] x);
    int n = 0;
    int r = 0;
    logic v;
    logic p = 1'b1;
    while (r < 2 && n < 60) begin
      @(posedge i_core_clk);
      n++;
      v = b ? pins.addr_latch_strobe : phase;
      if (v === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1) n = 0;
      end
      p = v;
    end
    cmp_flags(6'(n), x, 6'h3f);
  endtask
  // Each mode change is compared one edge after it shows
  always @(posedge i_core_clk) begin
    if (pend && q.size() == 0) report(8'(mode), 8'(last));
    else if (pend) begin
      e = q.pop_front();
      cmp_mode(mode, e);
      case (e)
        pmc_pkg::PMC_IDLE: begin
          cmp_pins(pins, {3'h6, ext, ext, 1'b0});
          cmp_flags(flags, 6'h30, 6'h3c);
        end
        pmc_pkg::PMC_IDLE_RST: cmp_flags(flags, 6'h0a, 6'h0e);
        pmc_pkg::PMC_PDOWN: begin
          cmp_pins(pins, {3'h0, ext, 2'h0});
          cmp_flags(flags, 6'h00, 6'h2c);
        end
        pmc_pkg::PMC_RESET: cmp_flags(flags, 6'h01, 6'h01);
        pmc_pkg::PMC_WAKE: cmp_flags(flags, 6'h00, 6'h01);
        pmc_pkg::PMC_EMUL: begin
          cmp_pins(pins, 6'h3d);
          cmp_flags(flags, 6'h20, 6'h20);
        end
        default: ;
      endcase
    end
    pend <= i_resetn && (mode !== last);
    last <= mode;
  end
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(87774));
    repeat (20) @(posedge i_core_clk);
    q.push_back(pmc_pkg::PMC_RUN);
    i_resetn <= 1'b1;
    wait_mode(pmc_pkg::PMC_RUN, 40);
    period(1'b0, 6'h02);
    period(1'b1, 6'h06);
    ext <= 1'($urandom_range(0, 1));
    enter(1'b1, 1'b0);
    q.push_back(pmc_pkg::PMC_RUN);
    any_irq <= 1'b1;
    wait_mode(pmc_pkg::PMC_RUN, 10);
    any_irq <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      irq_en <= i ? 2'h3 : 2'h1;
      irq_lvl <= i ? 2'h2 : 2'h3;
      enter(1'b1, 1'b1);
      pmc_ext_model_inst.wake(1 - i);
      cmp_mode(mode, pmc_pkg::PMC_PDOWN);
      q.push_back(pmc_pkg::PMC_WAKE);
      q.push_back(pmc_pkg::PMC_RUN);
      pmc_ext_model_inst.wake(i);
      for (int n = 0; n < 10 && resume !== 1'b1; n++) @(posedge i_core_clk);
      cmp_flags({5'h0, resume}, 6'h01, 6'h01);
      wait_mode(pmc_pkg::PMC_RUN, 10);
    end
    enter(1'b0, 1'b1);
    q.push_back(pmc_pkg::PMC_RESET);
    q.push_back(pmc_pkg::PMC_RUN);
    pmc_ext_model_inst.pin_reset(60, 1'b0);
    wait_mode(pmc_pkg::PMC_RUN, 40);
    enter(1'b1, 1'b0);
    q.push_back(pmc_pkg::PMC_IDLE_RST);
    q.push_back(pmc_pkg::PMC_RESET);
    q.push_back(pmc_pkg::PMC_RUN);
    fork
      pmc_ext_model_inst.pin_reset(60, 1'b0);
    join_none
    wait_mode(pmc_pkg::PMC_IDLE_RST, 10);
    wait_mode(pmc_pkg::PMC_RESET, 28);
    wait_mode(pmc_pkg::PMC_RUN, 80);
    pmc_ext_model_inst.pin_reset($urandom_range(4, 20), 1'b0);
    repeat (30) @(posedge i_core_clk);
    cmp_mode(mode, pmc_pkg::PMC_RUN);
    q.push_back(pmc_pkg::PMC_RESET);
    q.push_back(pmc_pkg::PMC_EMUL);
    pmc_ext_model_inst.pin_reset(60, 1'b1);
    wait_mode(pmc_pkg::PMC_EMUL, 40);
    q.push_back(pmc_pkg::PMC_RESET);
    q.push_back(pmc_pkg::PMC_RUN);
    pmc_ext_model_inst.pin_reset(60, 1'b0);
    wait_mode(pmc_pkg::PMC_RUN, 40);
    repeat (5) @(posedge i_core_clk);
    cmp_flags(6'(q.size()), 6'h00, 6'h3f);
    results();
  end
endmodule
